// File: psac_pkg.sv
/*
 * Shared constants for the program-space address and stack check block.
 * Assumes a 32-bit AXI4-Lite register bus and a CPU datapath with one core clock.
 */
package psac_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam logic [15:0] STACK_LOW_BOUND = 16'h0800;
    localparam logic [7:0] WINDOW_PAGE_ONLY = 8'h00;
    localparam logic [7:0] TABLE_PAGE_RST = 8'h00;
    localparam logic [15:0] SP_RST = 16'h0800;
    localparam int unsigned TBL_CFG_BIT = 7;
    localparam int unsigned EA_TOP_BIT = 15;
    localparam int unsigned WIN_EN_BIT = 2;
    // register byte addresses
    localparam logic [7:0] ADDR_SP = 8'h00;
    localparam logic [7:0] ADDR_LIMIT = 8'h04;
    localparam logic [7:0] ADDR_TBLPG = 8'h08;
    localparam logic [7:0] ADDR_WINPG = 8'h0C;
    localparam logic [7:0] ADDR_CORE = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // stack operation codes from the datapath
    typedef enum logic [1:0] {
        PSAC_OP_NONE = 2'b00,
        PSAC_OP_PUSH = 2'b01,
        PSAC_OP_POP = 2'b11,
        PSAC_OP_REF = 2'b10
    } psac_op_e;
    // push content kinds
    typedef enum logic [1:0] {
        PSAC_PV_DATA = 2'b00,
        PSAC_PV_CALL = 2'b01,
        PSAC_PV_EXC = 2'b11
    } psac_pv_e;
endpackage : psac_pkg

// File: psac_top.sv
/*
 * Program-space address generation and stack pointer checking.
 * Assumes the CPU datapath presents one stack or address request per cycle
 * and that software keeps a cycle between a limit write and a stack read.
 */
// Overview of operation
// - stack pointer points at first free word, stack grows upward
// - pop decrements pointer before access, push increments it after
// - call push clears the upper byte of the pushed counter word
// - exception push puts status low byte beside counter upper byte
// - limit register bit zero reads and holds zero after any write
// - limit register is not initialised by reset
// - push addresses compared with limit; push at limit ok, next traps
// - stack address below fixed lower bound raises a stack error trap
// - table address is table page above sixteen-bit effective address
// - table page top bit picks user or configuration space
// - window joins window page with low fifteen address bits
// - window accesses always drive program address bit 23 low
// - window address bit 15 comes from window page bit zero
// - window page register holds only the all-zero value
// - fetch address is zero, counter bits 22 to 1, then zero
// - window is read only and returns the low program word
// - table accesses reach every byte, no word alignment forced
// - table reads complete in configuration space
// - window remap only with address top bit and enable bit set
// - window remap suppressed during a table read or write
// - table writes to configuration space are blocked
`timescale 1ns/100ps
module psac_top
    import psac_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire psac_pkg::psac_op_e STACK_OP,
    input wire psac_pkg::psac_pv_e PUSH_KIND,
    input wire logic [22:0] PC_IN,
    input wire logic [7:0] STATUS_LOW_BYTE,
    input wire logic [15:0] EA_IN,
    input wire logic DATA_READ,
    input wire logic DATA_WRITE,
    input wire logic TABLE_READ_OP,
    input wire logic TABLE_WRITE_OP,
    output logic [15:0] STACK_ADDR,
    output logic [15:0] PUSH_DATA_LO,
    output logic [15:0] PUSH_DATA_HI,
    output logic STACK_ERR_TRAP,
    output logic [23:0] FETCH_ADDR,
    output logic [23:0] PROG_ADDR,
    output logic PROG_RD,
    output logic PROG_WR,
    output logic PROG_CFG_SPACE,
    output logic PROG_LOW_WORD_ONLY,
    output logic WINDOW_WR_REFUSED
);
    logic [15:0] stack_pointer_reg_r;
    logic [15:0] stack_limit_reg_r;
    logic [7:0] table_page_reg_r;
    logic [7:0] window_page_reg_r;
    logic [15:0] core_control_reg_r;
    logic trap_seen_r;
    logic [15:0] sp_nxt;
    logic [15:0] acc_addr;
    logic sp_used;
    logic over_err;
    logic under_err;
    logic table_busy;
    logic const_window_remap;
    logic cfg_wr_block;
    logic aw_got_r;
    logic w_got_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_fire;
    logic [31:0] rd_word;
    logic rd_hit;
    logic limit_wr;

    // pop pre-decrements, push uses the current pointer then increments
    always_comb begin
        sp_nxt = stack_pointer_reg_r;
        acc_addr = stack_pointer_reg_r;
        sp_used = 1'b0;
        case (STACK_OP)
            PSAC_OP_PUSH: begin
                sp_used = 1'b1;
                sp_nxt = stack_pointer_reg_r + 16'h0002;
            end
            PSAC_OP_POP: begin
                sp_used = 1'b1;
                acc_addr = stack_pointer_reg_r - 16'h0002;
                sp_nxt = acc_addr;
            end
            PSAC_OP_REF: sp_used = 1'b1;
            default: sp_used = 1'b0;
        endcase
    end

    // trap only once the pointer has passed the limit; equality is allowed
    assign over_err = sp_used && (STACK_OP == PSAC_OP_PUSH) &&
        (acc_addr > stack_limit_reg_r);
    assign under_err = sp_used && (acc_addr < STACK_LOW_BOUND);
    assign STACK_ERR_TRAP = over_err | under_err;
    assign STACK_ADDR = acc_addr;

    always_comb begin
        PUSH_DATA_LO = PC_IN[15:0];
        PUSH_DATA_HI = 16'h0000;
        case (PUSH_KIND)
            PSAC_PV_CALL: PUSH_DATA_HI = {8'h00, 1'b0, PC_IN[22:16]};
            PSAC_PV_EXC: PUSH_DATA_HI = {STATUS_LOW_BYTE, 1'b0, PC_IN[22:16]};
            default: PUSH_DATA_HI = 16'h0000;
        endcase
    end

    // sp register; software write has lower priority than datapath updates
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            stack_pointer_reg_r <= SP_RST;
        end else if (sp_used) begin
            stack_pointer_reg_r <= sp_nxt;
        end else if (wr_fire && aw_addr_r == ADDR_SP) begin
            stack_pointer_reg_r <= {w_data_r[15:1], 1'b0};
        end
    end

    assign limit_wr = wr_fire && (aw_addr_r == ADDR_LIMIT);
    // no reset: contents undefined until software writes them
    // a new limit is compared from the write edge on, the same edge that raises the write response
    always_ff @(posedge CORE_CLK) begin
        if (limit_wr) begin
            stack_limit_reg_r <= {w_data_r[15:1], 1'b0};
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            table_page_reg_r <= TABLE_PAGE_RST;
            window_page_reg_r <= WINDOW_PAGE_ONLY;
            core_control_reg_r <= 16'h0000;
        end else if (wr_fire) begin
            case (aw_addr_r)
                ADDR_TBLPG: table_page_reg_r <= w_data_r[7:0];
                // only one page value exists, writes cannot change it
                ADDR_WINPG: window_page_reg_r <= WINDOW_PAGE_ONLY;
                ADDR_CORE: core_control_reg_r <= w_data_r[15:0];
                default: table_page_reg_r <= table_page_reg_r;
            endcase
        end
    end

    // sticky trap seen flag; the set wins over a clear in the same cycle
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            trap_seen_r <= 1'b0;
        end else if (STACK_ERR_TRAP) begin
            trap_seen_r <= 1'b1;
        end else if (wr_fire && aw_addr_r == ADDR_STAT && w_data_r[0]) begin
            trap_seen_r <= 1'b0;
        end
    end

    // program-space address generation
    assign FETCH_ADDR = {1'b0, PC_IN[22:1], 1'b0};
    assign table_busy = TABLE_READ_OP | TABLE_WRITE_OP;
    assign const_window_remap = EA_IN[EA_TOP_BIT] && core_control_reg_r[WIN_EN_BIT] &&
        !table_busy && (DATA_READ | DATA_WRITE);
    assign cfg_wr_block = TABLE_WRITE_OP && table_page_reg_r[TBL_CFG_BIT];

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PROG_ADDR <= 24'h000000;
            PROG_RD <= 1'b0;
            PROG_WR <= 1'b0;
            PROG_CFG_SPACE <= 1'b0;
            PROG_LOW_WORD_ONLY <= 1'b0;
            WINDOW_WR_REFUSED <= 1'b0;
        end else if (table_busy) begin
            PROG_ADDR <= {table_page_reg_r, EA_IN};
            PROG_CFG_SPACE <= table_page_reg_r[TBL_CFG_BIT];
            PROG_RD <= TABLE_READ_OP;
            PROG_WR <= TABLE_WRITE_OP && !cfg_wr_block;
            PROG_LOW_WORD_ONLY <= 1'b0;
            WINDOW_WR_REFUSED <= 1'b0;
        end else if (const_window_remap) begin
            // top bit zero, page bit zero lands in bit 15
            PROG_ADDR <= {1'b0, window_page_reg_r, EA_IN[14:0]};
            PROG_CFG_SPACE <= 1'b0;
            PROG_RD <= DATA_READ;
            PROG_WR <= 1'b0;
            PROG_LOW_WORD_ONLY <= 1'b1;
            WINDOW_WR_REFUSED <= DATA_WRITE;
        end else begin
            PROG_RD <= 1'b0;
            PROG_WR <= 1'b0;
            PROG_LOW_WORD_ONLY <= 1'b0;
            WINDOW_WR_REFUSED <= 1'b0;
        end
    end

    // AXI4-Lite write: address and data taken in either order
    assign S_AXI_AWREADY = !aw_got_r && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_got_r && !S_AXI_BVALID;
    assign wr_fire = aw_got_r && w_got_r && !S_AXI_BVALID;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= {S_AXI_AWADDR[7:2], 2'b00};
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (aw_addr_r > ADDR_STAT) ? RESP_SLVERR : RESP_OKAY;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        case ({S_AXI_ARADDR[7:2], 2'b00})
            ADDR_SP: rd_word = {16'h0000, stack_pointer_reg_r};
            ADDR_LIMIT: rd_word = {16'h0000, stack_limit_reg_r};
            ADDR_TBLPG: rd_word = {24'h000000, table_page_reg_r};
            ADDR_WINPG: rd_word = {24'h000000, window_page_reg_r};
            ADDR_CORE: rd_word = {16'h0000, core_control_reg_r};
            ADDR_STAT: rd_word = {31'h00000000, trap_seen_r};
            default: begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign S_AXI_ARREADY = !S_AXI_RVALID;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_word;
            S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // stack side checks
    a_limit_lsb_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
        limit_wr |=> stack_limit_reg_r[0] == 1'b0)
        else $error("limit bit zero not clear");
    a_push_increments: assert property (@(posedge CORE_CLK) disable iff (RST)
        STACK_OP == PSAC_OP_PUSH |=> stack_pointer_reg_r == $past(stack_pointer_reg_r) + 16'h0002)
        else $error("push did not increment pointer");
    a_pop_predec: assert property (@(posedge CORE_CLK) disable iff (RST)
        STACK_OP == PSAC_OP_POP |-> STACK_ADDR == stack_pointer_reg_r - 16'h0002)
        else $error("pop address not predecremented");
    a_push_at_limit: assert property (@(posedge CORE_CLK) disable iff (RST)
        (STACK_OP == PSAC_OP_PUSH && stack_pointer_reg_r == stack_limit_reg_r &&
         stack_pointer_reg_r >= STACK_LOW_BOUND) |-> !STACK_ERR_TRAP)
        else $error("push at limit trapped");
    a_under_trap: assert property (@(posedge CORE_CLK) disable iff (RST)
        (sp_used && STACK_ADDR < STACK_LOW_BOUND) |-> STACK_ERR_TRAP)
        else $error("underflow not trapped");
    a_call_hi_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
        PUSH_KIND == PSAC_PV_CALL |-> PUSH_DATA_HI[15:7] == 9'h000)
        else $error("call push upper byte not clear");

    sequence s_push_on_limit;
        STACK_OP == PSAC_OP_PUSH && stack_pointer_reg_r == stack_limit_reg_r && !wr_fire;
    endsequence
    sequence s_quiet_cycle;
        STACK_OP == PSAC_OP_NONE && !wr_fire;
    endsequence
    // the push that lands on the limit is allowed, the next one must trap
    a_push_past_limit: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_push_on_limit ##1 s_quiet_cycle ##1 (STACK_OP == PSAC_OP_PUSH) |-> STACK_ERR_TRAP)
        else $error("push past limit not trapped");
    a_over_trap: assert property (@(posedge CORE_CLK) disable iff (RST)
        (STACK_OP == PSAC_OP_PUSH && stack_pointer_reg_r > stack_limit_reg_r) |-> STACK_ERR_TRAP)
        else $error("overflow push not trapped");
    a_trap_idle_low: assert property (@(posedge CORE_CLK) disable iff (RST)
        STACK_OP == PSAC_OP_NONE |-> !STACK_ERR_TRAP)
        else $error("trap raised with no stack use");
    a_trap_flag_set: assert property (@(posedge CORE_CLK) disable iff (RST)
        STACK_ERR_TRAP |=> trap_seen_r)
        else $error("trap seen flag not set");
    a_sp_aligned: assert property (@(posedge CORE_CLK) disable iff (RST)
        stack_pointer_reg_r[0] == 1'b0)
        else $error("stack pointer not word aligned");
    a_exc_status_byte: assert property (@(posedge CORE_CLK) disable iff (RST)
        PUSH_KIND == PSAC_PV_EXC |->
            PUSH_DATA_HI[15:8] == STATUS_LOW_BYTE && PUSH_DATA_HI[6:0] == PC_IN[22:16])
        else $error("exception push word wrong");

    // program address checks
    a_window_addr: assert property (@(posedge CORE_CLK) disable iff (RST)
        const_window_remap |=> PROG_ADDR[23] == 1'b0 && PROG_ADDR[14:0] == $past(EA_IN[14:0]))
        else $error("window address wrong");
    a_window_ro: assert property (@(posedge CORE_CLK) disable iff (RST)
        const_window_remap |=> !PROG_WR && PROG_LOW_WORD_ONLY)
        else $error("window access not read only");
    a_cfg_wr_block: assert property (@(posedge CORE_CLK) disable iff (RST)
        cfg_wr_block |=> !PROG_WR && PROG_CFG_SPACE)
        else $error("config table write performed");
    a_table_addr: assert property (@(posedge CORE_CLK) disable iff (RST)
        table_busy |=> PROG_ADDR == {$past(table_page_reg_r), $past(EA_IN)})
        else $error("table address wrong");
    a_table_odd_byte: assert property (@(posedge CORE_CLK) disable iff (RST)
        table_busy |=> PROG_ADDR[0] == $past(EA_IN[0]))
        else $error("table byte address forced aligned");
    a_fetch_align: assert property (@(posedge CORE_CLK) disable iff (RST)
        FETCH_ADDR[23] == 1'b0 && FETCH_ADDR[0] == 1'b0 && FETCH_ADDR[22:1] == PC_IN[22:1])
        else $error("fetch address wrong");
    a_table_space: assert property (@(posedge CORE_CLK) disable iff (RST)
        table_busy |=> PROG_CFG_SPACE == $past(table_page_reg_r[TBL_CFG_BIT]))
        else $error("table space select wrong");
    a_table_rd_cfg: assert property (@(posedge CORE_CLK) disable iff (RST)
        (TABLE_READ_OP && table_page_reg_r[TBL_CFG_BIT]) |=> PROG_RD)
        else $error("config table read blocked");
    a_table_wr_user: assert property (@(posedge CORE_CLK) disable iff (RST)
        (TABLE_WRITE_OP && !table_page_reg_r[TBL_CFG_BIT]) |=> PROG_WR)
        else $error("user table write blocked");
    a_window_page_bit: assert property (@(posedge CORE_CLK) disable iff (RST)
        const_window_remap |=> PROG_ADDR[EA_TOP_BIT] == $past(window_page_reg_r[0]) &&
            !PROG_CFG_SPACE)
        else $error("window page bit or space wrong");
    a_window_page_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
        window_page_reg_r == WINDOW_PAGE_ONLY)
        else $error("window page left its only value");
    a_window_gate: assert property (@(posedge CORE_CLK) disable iff (RST)
        ((DATA_READ || DATA_WRITE) && (table_busy || !EA_IN[EA_TOP_BIT] ||
            !core_control_reg_r[WIN_EN_BIT])) |=> !PROG_LOW_WORD_ONLY && !WINDOW_WR_REFUSED)
        else $error("window remap outside its conditions");

    // register bus answers
    a_read_answer: assert property (@(posedge CORE_CLK) disable iff (RST)
        (S_AXI_ARVALID && S_AXI_ARREADY) |=> S_AXI_RVALID)
        else $error("read not answered");
    a_write_answer: assert property (@(posedge CORE_CLK) disable iff (RST)
        wr_fire |=> S_AXI_BVALID)
        else $error("write not answered");
endmodule : psac_top

// File: psac_cpu_model.sv
/*
 * CPU datapath model: presents stack, table and data requests to the block.
 * Assumes the bench calls req and then idle, one request per cycle.
 */
`timescale 1ns/100ps
module psac_cpu_model
    import psac_pkg::*;
(
    input wire logic clk,
    output psac_pkg::psac_op_e stack_op,
    output psac_pkg::psac_pv_e push_kind,
    output logic [22:0] pc,
    output logic [7:0] status_low,
    output logic [15:0] ea,
    output logic [3:0] acc
);
    initial begin
        stack_op = PSAC_OP_NONE;
        push_kind = PSAC_PV_DATA;
        pc = '0;
        status_low = '0;
        ea = '0;
        acc = '0;
    end

    // acc is {data read, data write, table read, table write}
    task automatic req(input psac_op_e o, input psac_pv_e k, input logic [22:0] p,
        input logic [7:0] s, input logic [15:0] a, input logic [3:0] c);
        @(posedge clk);
        stack_op <= o;
        push_kind <= k;
        pc <= p;
        status_low <= s;
        ea <= a;
        acc <= c;
        @(negedge clk);
    endtask : req

    task automatic idle;
        @(posedge clk);
        stack_op <= PSAC_OP_NONE;
        acc <= '0;
        // released address lines must not keep showing the last value
        ea <= ~ea;
        @(negedge clk);
    endtask : idle
endmodule : psac_cpu_model

// File: tb_program_space_addr_stack_check.sv
/*
 * Self-checking bench for psac_top: AXI4-Lite register access, stack checks
 * and program address generation. Assumes the datapath model psac_cpu_model.
 */
`timescale 1ns/100ps
module tb_program_space_addr_stack_check;
    import psac_pkg::*;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, trap;
    logic arvalid, arready, rvalid, rready, prd, pwr, pcfg, plow, wref;
    logic [7:0] awaddr, araddr, stat;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r, wr_resp;
    logic [15:0] ea, stack_addr, push_lo, push_hi;
    logic [22:0] pc;
    logic [23:0] fetch, paddr;
    logic [3:0] acc;
    psac_op_e op;
    psac_pv_e kind;
    int n_fail = 0;
    int checks = 0;

    psac_cpu_model i_cpu (.clk(clk), .stack_op(op), .push_kind(kind), .pc(pc),
        .status_low(stat), .ea(ea), .acc(acc));
    psac_top i_dut (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .STACK_OP(op), .PUSH_KIND(kind), .PC_IN(pc),
        .STATUS_LOW_BYTE(stat), .EA_IN(ea), .DATA_READ(acc[3]), .DATA_WRITE(acc[2]),
        .TABLE_READ_OP(acc[1]), .TABLE_WRITE_OP(acc[0]), .STACK_ADDR(stack_addr),
        .PUSH_DATA_LO(push_lo), .PUSH_DATA_HI(push_hi), .STACK_ERR_TRAP(trap),
        .FETCH_ADDR(fetch), .PROG_ADDR(paddr), .PROG_RD(prd), .PROG_WR(pwr),
        .PROG_CFG_SPACE(pcfg), .PROG_LOW_WORD_ONLY(plow), .WINDOW_WR_REFUSED(wref));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        checks++;
        if (s !== x) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask : chk

    task automatic tmo(input int n);
        if (n >= 20) begin
            n_fail++;
            $display("mismatch handshake expected answer seen none");
            end_sim();
        end
    endtask : tmo

    // readies are looked at mid-cycle, so the release lands on the taking edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(negedge clk);
            ta = awready;
            tw = wready;
            tb = bvalid;
            wr_resp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) break;
        end
        bready <= 1'b0;
        tmo(n);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        int n;
        logic ta, tb;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(negedge clk);
            ta = arready;
            tb = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tb) break;
        end
        rready <= 1'b0;
        tmo(n);
    endtask : axi_rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] x, input logic [1:0] xr);
        axi_rd(a);
        chk("rdata", x, d);
        chk("rresp", xr, r);
    endtask : rchk

    task automatic wchk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] xr);
        axi_wr(a, v);
        chk("bresp", xr, wr_resp);
    endtask : wchk

    task automatic stk(input psac_op_e o, input psac_pv_e k, input logic [15:0] xa,
        input logic xt, input logic [15:0] xh);
        i_cpu.req(o, k, 23'h7ABCDF, 8'hA5, 16'h0000, 4'h0);
        chk("stack_addr", xa, stack_addr);
        chk("trap", xt, trap);
        chk("push_hi", xh, push_hi);
        chk("push_lo", 16'hBCDF, push_lo);
        chk("fetch", 24'h7ABCDE, fetch);
        i_cpu.idle();
    endtask : stk

    // m[5] enables the address compare, m[4:0] masks the flag compare
    task automatic prg(input logic [3:0] c, input logic [15:0] a, input logic [23:0] xa,
        input logic [4:0] xf, input logic [5:0] m);
        i_cpu.req(PSAC_OP_NONE, PSAC_PV_DATA, 23'h7ABCDF, 8'hA5, a, c);
        i_cpu.idle();
        if (m[5]) chk("prog_addr", xa, paddr);
        chk("prog_flags", xf & m[4:0], {prd, pwr, pcfg, plow, wref} & m[4:0]);
    endtask : prg

    task automatic t_regs;
        rchk(ADDR_SP, {16'h0000, SP_RST}, RESP_OKAY);
        wchk(ADDR_LIMIT, 32'h00000A01, RESP_OKAY);
        rchk(ADDR_LIMIT, 32'h00000A00, RESP_OKAY);
        wchk(8'h18, 32'h00000055, RESP_SLVERR);
        rchk(ADDR_LIMIT, 32'h00000A00, RESP_OKAY);
        axi_wr(ADDR_WINPG, 32'h00000033);
        rchk(ADDR_WINPG, 32'h00000000, RESP_OKAY);
        rchk(8'h18, 32'h00000000, RESP_SLVERR);
    endtask : t_regs

    task automatic t_stack;
        axi_wr(ADDR_LIMIT, 32'h00000802);
        i_cpu.idle();
        stk(PSAC_OP_PUSH, PSAC_PV_CALL, 16'h0800, 1'b0, 16'h007A);
        stk(PSAC_OP_PUSH, PSAC_PV_EXC, 16'h0802, 1'b0, 16'hA57A);
        stk(PSAC_OP_PUSH, PSAC_PV_DATA, 16'h0804, 1'b1, 16'h0000);
        rchk(ADDR_SP, 32'h00000806, RESP_OKAY);
        stk(PSAC_OP_POP, PSAC_PV_DATA, 16'h0804, 1'b0, 16'h0000);
        axi_wr(ADDR_SP, 32'h00000800);
        stk(PSAC_OP_POP, PSAC_PV_DATA, 16'h07FE, 1'b1, 16'h0000);
        stk(PSAC_OP_REF, PSAC_PV_DATA, 16'h07FE, 1'b1, 16'h0000);
    endtask : t_stack

    task automatic t_prog;
        axi_wr(ADDR_TBLPG, 32'h00000085);
        axi_wr(ADDR_CORE, 32'h00000004);
        prg(4'b0010, 16'h1235, 24'h851235, 5'b10100, 6'h3F);
        prg(4'b0001, 16'h1235, 24'h000000, 5'b00000, 6'h08);
        prg(4'b1000, 16'h9234, 24'h001234, 5'b10010, 6'h3F);
        prg(4'b0100, 16'h9234, 24'h000000, 5'b00001, 6'h09);
        prg(4'b1010, 16'h9234, 24'h859234, 5'b10100, 6'h3F);
        axi_wr(ADDR_TBLPG, 32'h00000005);
        prg(4'b0001, 16'h0011, 24'h050011, 5'b01000, 6'h3F);
        axi_wr(ADDR_CORE, 32'h00000000);
        prg(4'b1000, 16'h9234, 24'h000000, 5'b00000, 6'h13);
    endtask : t_prog

    // the sticky trap flag is set by t_stack and cleared by a write of one
    task automatic t_stat;
        rchk(ADDR_STAT, 32'h00000001, RESP_OKAY);
        wchk(ADDR_STAT, 32'h00000001, RESP_OKAY);
        rchk(ADDR_STAT, 32'h00000000, RESP_OKAY);
    endtask : t_stat

    // second reset mid-run: the limit keeps its value, the rest returns to reset
    task automatic t_rst;
        stk(PSAC_OP_REF, PSAC_PV_DATA, 16'h07FE, 1'b1, 16'h0000);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk(ADDR_STAT, 32'h00000000, RESP_OKAY);
        rchk(ADDR_SP, {16'h0000, SP_RST}, RESP_OKAY);
        rchk(ADDR_LIMIT, 32'h00000802, RESP_OKAY);
        rchk(ADDR_CORE, 32'h00000000, RESP_OKAY);
        rchk(ADDR_TBLPG, {24'h000000, TABLE_PAGE_RST}, RESP_OKAY);
    endtask : t_rst

    initial begin
        rst = 1'b1;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_stack();
        t_stat();
        t_prog();
        t_rst();
        end_sim();
    end
endmodule : tb_program_space_addr_stack_check
